/* rtl/ssc_consts.svh */
// Widths, reset values and timing constants of the switching logic
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
`define SSC_VAL_W 16
`define SSC_CNT_W 16
`define SSC_CLK_PERIOD_NS 10
`define SSC_BOOL_LAT_NS 2000000
`define SSC_SYNC_W 3
`define SSC_RST_SP1 16'h8000
`define SSC_RST_SP2 16'h4000
`define SSC_RST_CNT 16'h0000
`define SSC_RST_SEC_EN 1'b0
`define SSC_RST_SEC_IN 1'b1
`define SSC_RST_INVERT 1'b0
`endif

/* rtl/ssc_pkg.sv */
// Types shared by the switching channel logic
`default_nettype none
`include "ssc_consts.svh"
package ssc_pkg;
  typedef enum logic [1:0] {
    CMP_SINGLE = 2'b00,
    CMP_WINDOW = 2'b01,
    CMP_HYST = 2'b10
  } cmp_mode_t;
  typedef enum logic [1:0] {
    SHOT_OFF = 2'b00,
    SHOT_UP = 2'b01,
    SHOT_DOWN = 2'b10
  } shot_mode_t;
  typedef enum logic [1:0] {
    BOOL_NONE = 2'b00,
    BOOL_AND = 2'b01,
    BOOL_OR = 2'b10
  } bool_mode_t;
  typedef enum logic {
    LINK_SIO = 1'b0,
    LINK_IOL = 1'b1
  } link_state_t;
  typedef struct packed {
    cmp_mode_t cmp_mode;
    logic invert;
    logic [`SSC_VAL_W-1:0] sp1;
    logic [`SSC_VAL_W-1:0] sp2;
    logic delay_en;
    logic [`SSC_CNT_W-1:0] delay_cyc;
    logic stretch_en;
    logic [`SSC_CNT_W-1:0] stretch_cyc;
    shot_mode_t shot;
    logic [`SSC_CNT_W-1:0] pulse_cyc;
  } chan_cfg_t;
  typedef struct packed {
    chan_cfg_t prim;
    chan_cfg_t sec;
    logic sec_en;
    logic sec_is_input;
    bool_mode_t bool_mode;
  } dev_cfg_t;
endpackage : ssc_pkg
`default_nettype wire

/* rtl/ssc_compare.sv */
// Setpoint comparison of one switching channel
`default_nettype none
`include "ssc_consts.svh"
module ssc_compare import ssc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Value and configuration
  input wire logic [`SSC_VAL_W-1:0] val_i,
  input wire chan_cfg_t cfg_i,
  // Result
  output logic res_o
);
  logic res_ff;
  logic [`SSC_VAL_W-1:0] lo;
  logic [`SSC_VAL_W-1:0] hi;

  // Window bounds accept the setpoints in either order
  assign lo = (cfg_i.sp1 < cfg_i.sp2) ? cfg_i.sp1 : cfg_i.sp2;
  assign hi = (cfg_i.sp1 < cfg_i.sp2) ? cfg_i.sp2 : cfg_i.sp1;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      res_ff <= 1'b0;
    end else begin
      case (cfg_i.cmp_mode)
        CMP_SINGLE: res_ff <= (val_i >= cfg_i.sp1);
        CMP_WINDOW: res_ff <= (val_i >= lo) && (val_i <= hi);
        CMP_HYST: begin
          // Between the setpoints the last state is held
          if (val_i <= cfg_i.sp2) begin
            res_ff <= 1'b1;
          end else if (val_i >= cfg_i.sp1) begin
            res_ff <= 1'b0;
          end
        end
        default: res_ff <= 1'b0;
      endcase
    end
  end
  assign res_o = res_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_single;
    (cfg_i.cmp_mode == CMP_SINGLE) |=> (res_ff == ($past(val_i) >=
      $past(cfg_i.sp1)));
  endproperty
  a_single: assert property (p_single) else $error("single point");

  property p_window_out;
    (cfg_i.cmp_mode == CMP_WINDOW && (val_i < lo || val_i > hi)) |=> !res_ff;
  endproperty
  a_window_out: assert property (p_window_out)
    else $error("window outside not low");

  property p_hyst_hold;
    (cfg_i.cmp_mode == CMP_HYST && $past(cfg_i.cmp_mode) == CMP_HYST &&
      val_i > cfg_i.sp2 && val_i < cfg_i.sp1) |=> $stable(res_ff);
  endproperty
  a_hyst_hold: assert property (p_hyst_hold)
    else $error("hysteresis changed between setpoints");
endmodule : ssc_compare
`default_nettype wire

/* rtl/ssc_shaper.sv */
// Inversion, delay, stretch and one-shot shaping of one channel
`default_nettype none
`include "ssc_consts.svh"
module ssc_shaper import ssc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Comparison result and configuration
  input wire logic res_i,
  input wire chan_cfg_t cfg_i,
  // Shaped signal
  output logic sig_o
);
  logic raw;
  logic dly_ff;
  logic dly_prev_ff;
  logic [`SSC_CNT_W-1:0] dcnt_ff;
  logic [`SSC_CNT_W-1:0] hcnt_ff;
  logic out_ff;
  logic edge_up;
  logic edge_dn;
  logic trig;

  assign raw = res_i ^ cfg_i.invert;

  // A change must persist delay_cyc cycles before it passes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dly_ff <= 1'b0;
      dcnt_ff <= `SSC_RST_CNT;
    end else if (!cfg_i.delay_en || raw == dly_ff) begin
      dly_ff <= raw;
      dcnt_ff <= `SSC_RST_CNT;
    end else if (({1'b0, dcnt_ff} + 17'h00001) >= {1'b0, cfg_i.delay_cyc})
    begin
      dly_ff <= raw;
      dcnt_ff <= `SSC_RST_CNT;
    end else begin
      dcnt_ff <= dcnt_ff + 16'h0001;
    end
  end

  assign edge_up = dly_ff && !dly_prev_ff;
  assign edge_dn = !dly_ff && dly_prev_ff;
  assign trig = (cfg_i.shot == SHOT_UP) ? edge_up : edge_dn;

  // Stretch follows delay, so both may be enabled together
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dly_prev_ff <= 1'b0;
      hcnt_ff <= `SSC_RST_CNT;
      out_ff <= 1'b0;
    end else begin
      dly_prev_ff <= dly_ff;
      if (cfg_i.shot != SHOT_OFF) begin
        if (trig) begin
          out_ff <= 1'b1;
          hcnt_ff <= (cfg_i.pulse_cyc == 16'h0000) ? 16'h0000 :
            cfg_i.pulse_cyc - 16'h0001;
        end else if (hcnt_ff != 16'h0000) begin
          hcnt_ff <= hcnt_ff - 16'h0001;
        end else begin
          out_ff <= 1'b0;
        end
      end else if (cfg_i.stretch_en) begin
        out_ff <= dly_ff || (hcnt_ff != 16'h0000);
        if (edge_up) begin
          hcnt_ff <= (cfg_i.stretch_cyc == 16'h0000) ? 16'h0000 :
            cfg_i.stretch_cyc - 16'h0001;
        end else if (hcnt_ff != 16'h0000) begin
          hcnt_ff <= hcnt_ff - 16'h0001;
        end
      end else begin
        out_ff <= dly_ff;
        hcnt_ff <= `SSC_RST_CNT;
      end
    end
  end
  assign sig_o = out_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_delay;
    (cfg_i.delay_en && $past(cfg_i.delay_en) && $changed(dly_ff)) |->
      (({1'b0, $past(dcnt_ff)} + 17'h00001) >= {1'b0, $past(cfg_i.delay_cyc)});
  endproperty
  a_delay: assert property (p_delay) else $error("delay too short");

  property p_stretch;
    (cfg_i.shot == SHOT_OFF && cfg_i.stretch_en && hcnt_ff != 16'h0000)
      |=> out_ff;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch cut");

  sequence s_up_edge;
    cfg_i.shot == SHOT_UP && edge_up;
  endsequence
  property p_shot_up;
    s_up_edge |=> out_ff ##1 (out_ff || cfg_i.pulse_cyc < 16'h0002);
  endproperty
  a_shot_up: assert property (p_shot_up) else $error("no one-shot");
endmodule : ssc_shaper
`default_nettype wire

/* rtl/switching_signal_channel_logic.sv */
// Top of the two-channel switching signal logic with mode and pin control
//
// Notes on behaviour
// - Primary channel starts in standard I/O mode.
// - Master wake-up pulse switches to IO-Link mode.
// - Default: one single-point channel on primary line.
// - Optional secondary channel, standard I/O, input or output.
// - Single-point high at setpoint, optionally inverted.
// - Window high between setpoints, low outside.
// - Hysteresis: set at second, clear at first.
// - Delay postpones every change; short changes suppressed.
// - Delay and stretch may run together.
// - Stretch holds each pulse a minimum time.
// - One-shot pulse on leading or trailing edge.
// - Boolean combine only with secondary as input.
// - AND: output high only when both active.
// - AND result appears after two milliseconds.
// - OR: high secondary input overrides result.
// - OR result likewise delayed two milliseconds.
// - Mode settings may change at run time.
`default_nettype none
`include "ssc_consts.svh"
module switching_signal_channel_logic import ssc_pkg::*; #(
  parameter int unsigned BOOL_LAT_CYC = `SSC_BOOL_LAT_NS / `SSC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Configuration from the link stack or teach logic
  input wire dev_cfg_t cfg_i,
  input wire logic cfg_load_i,
  // Measurement
  input wire logic [`SSC_VAL_W-1:0] meas_i,
  // Link stack side
  input wire logic wake_pulse_i,
  input wire logic link_fallback_i,
  input wire logic link_txd_i,
  input wire logic link_tx_en_i,
  output logic link_rxd_o,
  output logic io_link_mode_o,
  // Primary output line pin
  input wire logic primary_output_line_i,
  output logic primary_output_line_o,
  output logic primary_output_line_oe_n_o,
  // Secondary line pin
  input wire logic secondary_io_line_i,
  output logic secondary_io_line_o,
  output logic secondary_io_line_oe_n_o,
  // Status
  output logic prim_result_o,
  output logic sec_input_o
);
  localparam int LAT_W = $clog2(BOOL_LAT_CYC + 1);

  dev_cfg_t cfg_ff;
  link_state_t link_ff;
  link_state_t nxt_link;
  logic [`SSC_SYNC_W-1:0] sync1_ff;
  logic [`SSC_SYNC_W-1:0] sync2_ff;
  logic wake_prev_ff;
  logic wake_rise;
  logic prim_res;
  logic sec_res;
  logic prim_shaped;
  logic sec_shaped;
  logic sec_in;
  logic bool_active;
  logic comb_ff;
  logic lat_ff;
  logic [LAT_W-1:0] lat_cnt_ff;
  logic prim_sig;
  logic prim_o_ff;
  logic prim_oe_n_ff;
  logic sec_o_ff;
  logic sec_oe_n_ff;
  logic rxd_ff;
  logic res_out_ff;
  logic sec_out_ff;

  ////////////////////////////////////////////////////////////////////////
  // Configuration: defaults after reset, reloadable at any time
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= '0;
      cfg_ff.prim.cmp_mode <= CMP_SINGLE;
      cfg_ff.prim.invert <= `SSC_RST_INVERT;
      cfg_ff.prim.sp1 <= `SSC_RST_SP1;
      cfg_ff.prim.sp2 <= `SSC_RST_SP2;
      cfg_ff.sec.sp1 <= `SSC_RST_SP1;
      cfg_ff.sec.sp2 <= `SSC_RST_SP2;
      cfg_ff.sec_en <= `SSC_RST_SEC_EN;
      cfg_ff.sec_is_input <= `SSC_RST_SEC_IN;
      cfg_ff.bool_mode <= BOOL_NONE;
    end else if (cfg_load_i) begin
      cfg_ff <= cfg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: wake, primary line, secondary line
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      wake_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {secondary_io_line_i, primary_output_line_i, wake_pulse_i};
      sync2_ff <= sync1_ff;
      wake_prev_ff <= sync2_ff[0];
    end
  end
  assign wake_rise = sync2_ff[0] && !wake_prev_ff;
  assign sec_in = sync2_ff[2];

  ////////////////////////////////////////////////////////////////////////
  // Line mode: standard I/O until a wake-up, back on a fallback
  always_comb begin
    case (link_ff)
      LINK_SIO: nxt_link = wake_rise ? LINK_IOL : LINK_SIO;
      LINK_IOL: nxt_link = link_fallback_i ? LINK_SIO : LINK_IOL;
      default: nxt_link = LINK_SIO;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link_ff <= LINK_SIO;
    end else begin
      link_ff <= nxt_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Both channels: comparison, then shaping
  ssc_compare u_prim_cmp (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .val_i (meas_i),
    .cfg_i (cfg_ff.prim),
    .res_o (prim_res)
  );

  ssc_shaper u_prim_shape (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .res_i (prim_res),
    .cfg_i (cfg_ff.prim),
    .sig_o (prim_shaped)
  );

  ssc_compare u_sec_cmp (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .val_i (meas_i),
    .cfg_i (cfg_ff.sec),
    .res_o (sec_res)
  );

  ssc_shaper u_sec_shape (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .res_i (sec_res),
    .cfg_i (cfg_ff.sec),
    .sig_o (sec_shaped)
  );

  ////////////////////////////////////////////////////////////////////////
  // Boolean stage, last in the chain
  assign bool_active = cfg_ff.sec_en && cfg_ff.sec_is_input &&
    (cfg_ff.bool_mode != BOOL_NONE);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      comb_ff <= 1'b0;
    end else if (cfg_ff.bool_mode == BOOL_AND) begin
      comb_ff <= prim_shaped && sec_in;
    end else begin
      comb_ff <= prim_shaped || sec_in;
    end
  end

  // Latency acts as a settle filter: a level must hold the full two
  // milliseconds to appear, so glitches shorter than that are lost.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lat_ff <= 1'b0;
      lat_cnt_ff <= '0;
    end else if (comb_ff == lat_ff) begin
      lat_cnt_ff <= '0;
    end else if (32'(lat_cnt_ff) + 32'd1 >= BOOL_LAT_CYC) begin
      lat_ff <= comb_ff;
      lat_cnt_ff <= '0;
    end else begin
      lat_cnt_ff <= lat_cnt_ff + 1'b1;
    end
  end

  assign prim_sig = bool_active ? lat_ff : prim_shaped;

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers; in IO-Link mode the link stack owns the primary line
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prim_o_ff <= 1'b0;
      prim_oe_n_ff <= 1'b0;
    end else if (link_ff == LINK_SIO) begin
      prim_o_ff <= prim_sig;
      prim_oe_n_ff <= 1'b0;
    end else begin
      prim_o_ff <= link_txd_i;
      prim_oe_n_ff <= !link_tx_en_i;
    end
  end

  // The secondary line never carries IO-Link traffic
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sec_o_ff <= 1'b0;
      sec_oe_n_ff <= 1'b1;
    end else if (cfg_ff.sec_en && !cfg_ff.sec_is_input) begin
      sec_o_ff <= sec_shaped;
      sec_oe_n_ff <= 1'b0;
    end else begin
      sec_o_ff <= 1'b0;
      sec_oe_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_ff <= 1'b0;
      res_out_ff <= 1'b0;
      sec_out_ff <= 1'b0;
    end else begin
      rxd_ff <= sync2_ff[1];
      res_out_ff <= prim_sig;
      sec_out_ff <= cfg_ff.sec_en && cfg_ff.sec_is_input && sec_in;
    end
  end

  assign link_rxd_o = rxd_ff;
  assign io_link_mode_o = (link_ff == LINK_IOL);
  assign primary_output_line_o = prim_o_ff;
  assign primary_output_line_oe_n_o = prim_oe_n_ff;
  assign secondary_io_line_o = sec_o_ff;
  assign secondary_io_line_oe_n_o = sec_oe_n_ff;
  assign prim_result_o = res_out_ff;
  assign sec_input_o = sec_out_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_stay_sio;
    (link_ff == LINK_SIO && !wake_rise) |=> (link_ff == LINK_SIO);
  endproperty
  a_stay_sio: assert property (p_stay_sio) else $error("left STANDARD_IO_MODE");

  sequence s_wake;
    link_ff == LINK_SIO && wake_rise;
  endsequence
  property p_wake;
    s_wake |=> io_link_mode_o ##1 (primary_output_line_oe_n_o ==
      !$past(link_tx_en_i) || !io_link_mode_o);
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");

  property p_sec_off;
    !(cfg_ff.sec_en && !cfg_ff.sec_is_input) |=> secondary_io_line_oe_n_o;
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("sec drives");

  property p_sio_drive;
    (link_ff == LINK_SIO) |=> (!primary_output_line_oe_n_o &&
      primary_output_line_o == $past(prim_sig));
  endproperty
  a_sio_drive: assert property (p_sio_drive) else $error("STANDARD_IO_MODE drive");

  property p_no_bool;
    !bool_active |=> (prim_result_o == $past(prim_shaped));
  endproperty
  a_no_bool: assert property (p_no_bool) else $error("bool leak");

  property p_and;
    (cfg_ff.bool_mode == BOOL_AND && !sec_in) |=> !comb_ff;
  endproperty
  a_and: assert property (p_and) else $error("AND without enable");

  property p_or;
    (cfg_ff.bool_mode == BOOL_OR && sec_in) |=> comb_ff;
  endproperty
  a_or: assert property (p_or) else $error("OR not overriding");

  property p_latency;
    $changed(lat_ff) |-> (32'($past(lat_cnt_ff)) + 32'd1 >= BOOL_LAT_CYC &&
      $past(comb_ff) == lat_ff);
  endproperty
  a_latency: assert property (p_latency) else $error("latency");
endmodule : switching_signal_channel_logic
`default_nettype wire

/* test/far_side_model.sv */
// Far-side model: link master wake pulse, line pull-down, two-state sensor
`default_nettype none
module far_side_model #(
  parameter int WAKE_CYC = 8
) (
  // Clock
  input wire logic clk_sys_i,
  // Bench commands
  input wire logic wake_go_i,
  input wire logic sensor_lvl_i,
  // Device pins
  input wire logic prim_o_i,
  input wire logic prim_oe_n_i,
  input wire logic sec_o_i,
  input wire logic sec_oe_n_i,
  output logic wake_pulse_o,
  output logic prim_pin_o,
  output logic sec_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Wake request is one long high pulse, not a level
  always @(posedge clk_sys_i) begin
    if (wake_go_i) begin
      cnt <= WAKE_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign wake_pulse_o = (cnt > 0);
  // Master input has a pull-down, so a released line reads low
  assign prim_pin_o = prim_oe_n_i ? 1'b0 : prim_o_i;
  // Sensor drives the line only while the device leaves it
  assign sec_pin_o = sec_oe_n_i ? sensor_lvl_i : sec_o_i;
endmodule : far_side_model
`default_nettype wire

/* test/tb.sv */
// Self-checking bench of the switching signal channel logic
`default_nettype none
`include "ssc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  localparam int LAT = 20;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_load_i = 1'b0;
  logic wake_go = 1'b0;
  logic lvl = 1'b0;
  logic link_txd_i = 1'b0;
  logic link_tx_en_i = 1'b0;
  logic link_fallback_i = 1'b0;
  logic [`SSC_VAL_W-1:0] meas_i = 16'h0000;
  dev_cfg_t cfg_i = '0;
  logic wake_pulse_i, prim_pin, sec_pin, link_rxd_o, io_link_mode_o;
  logic prim_o, prim_oe_n, sec_o, sec_oe_n, prim_result_o, sec_input_o;
  int err_count = 0;
  int cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;

  switching_signal_channel_logic #(.BOOL_LAT_CYC(LAT))
    switching_signal_channel_logic_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_i(cfg_i),
    .cfg_load_i(cfg_load_i), .meas_i(meas_i), .wake_pulse_i(wake_pulse_i),
    .link_fallback_i(link_fallback_i), .link_txd_i(link_txd_i),
    .link_tx_en_i(link_tx_en_i), .link_rxd_o(link_rxd_o),
    .io_link_mode_o(io_link_mode_o), .primary_output_line_i(prim_pin),
    .primary_output_line_o(prim_o), .primary_output_line_oe_n_o(prim_oe_n),
    .secondary_io_line_i(sec_pin), .secondary_io_line_o(sec_o),
    .secondary_io_line_oe_n_o(sec_oe_n), .prim_result_o(prim_result_o),
    .sec_input_o(sec_input_o));

  far_side_model far_side_model_inst (
    .clk_sys_i(clk_sys_i), .wake_go_i(wake_go), .sensor_lvl_i(lvl),
    .prim_o_i(prim_o), .prim_oe_n_i(prim_oe_n), .sec_o_i(sec_o),
    .sec_oe_n_i(sec_oe_n), .wake_pulse_o(wake_pulse_i),
    .prim_pin_o(prim_pin), .sec_pin_o(sec_pin));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : check

  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc

  task automatic set_meas(logic [15:0] v);
    @(posedge clk_sys_i);
    meas_i <= v;
  endtask : set_meas

  task automatic set_lvl(logic v);
    @(posedge clk_sys_i);
    lvl <= v;
  endtask : set_lvl

  task automatic load(dev_cfg_t c);
    @(posedge clk_sys_i);
    cfg_i <= c;
    cfg_load_i <= 1'b1;
    @(posedge clk_sys_i);
    cfg_load_i <= 1'b0;
  endtask : load

  function automatic dev_cfg_t dflt();
    dev_cfg_t c;
    c = '0;
    c.prim.sp1 = `SSC_RST_SP1;
    c.prim.sp2 = `SSC_RST_SP2;
    c.sec_is_input = `SSC_RST_SEC_IN;
    return c;
  endfunction : dflt

  task automatic count_high(int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (prim_result_o === 1'b1) k++;
    end
  endtask : count_high

  // Bounded wait on the final signal; running out ends the run
  task automatic wait_res(logic v, int max);
    for (int i = 0; i < max; i++) begin
      @(negedge clk_sys_i);
      if (prim_result_o === v) return;
    end
    check("wait result", prim_result_o, v);
    end_of_test();
  endtask : wait_res

  task automatic run_tab(string n, dev_cfg_t c, logic [15:0] v [4],
                         logic [3:0] e);
    load(c);
    for (int i = 0; i < 4; i++) begin
      set_meas(v[i]);
      cyc(5);
      check(n, prim_result_o, e[i]);
      check(n, prim_o, e[i]);
    end
  endtask : run_tab

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("link mode", io_link_mode_o, 1'b0);
    check("prim oe_n", prim_oe_n, 1'b0);
    check("sec oe_n", sec_oe_n, 1'b1);
    set_meas(16'h8000);
    cyc(5);
    check("default single", prim_result_o, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_tables();
    dev_cfg_t c;
    c = dflt();
    run_tab("single", c, '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000},
            4'b0110);
    c.prim.invert = 1'b1;
    run_tab("inverted", c, '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000},
            4'b1001);
    c = dflt();
    c.prim.cmp_mode = CMP_WINDOW;
    c.prim.sp1 = 16'h1000;
    c.prim.sp2 = 16'h2000;
    run_tab("window", c, '{16'h0FFF, 16'h1000, 16'h2000, 16'h2001},
            4'b0110);
    c.prim.cmp_mode = CMP_HYST;
    c.prim.sp1 = 16'h3000;
    c.prim.sp2 = 16'h1000;
    run_tab("hysteresis", c, '{16'h1000, 16'h2000, 16'h3000, 16'h2000},
            4'b0011);
    $display("test tables done");
  endtask : t_tables

  task automatic t_delay();
    dev_cfg_t c;
    int k;
    c = dflt();
    c.prim.delay_en = 1'b1;
    c.prim.delay_cyc = 16'h0008;
    set_meas(16'h0000);
    load(c);
    cyc(10);
    set_meas(16'hFFFF);
    repeat (3) @(posedge clk_sys_i);
    set_meas(16'h0000);
    count_high(25, k);
    check("short change", k[15:0], 16'h0000);
    set_meas(16'hFFFF);
    cyc(6);
    check("delayed rise", prim_result_o, 1'b0);
    wait_res(1'b1, 20);
    set_meas(16'h0000);
    cyc(6);
    check("delayed fall", prim_result_o, 1'b1);
    wait_res(1'b0, 20);
    // Short source pulse, delay and stretch both active
    c.prim.delay_cyc = 16'h0004;
    c.prim.stretch_en = 1'b1;
    c.prim.stretch_cyc = 16'h0014;
    load(c);
    set_meas(16'hFFFF);
    repeat (6) @(posedge clk_sys_i);
    set_meas(16'h0000);
    count_high(60, k);
    check("stretch length", (k >= 20), 1'b1);
    check("stretch end", prim_result_o, 1'b0);
    $display("test delay done");
  endtask : t_delay

  task automatic t_shot();
    dev_cfg_t c;
    int k;
    c = dflt();
    c.prim.pulse_cyc = 16'h0005;
    for (int m = 0; m < 2; m++) begin
      c.prim.shot = m ? SHOT_DOWN : SHOT_UP;
      load(c);
      cyc(10);
      for (int s = 0; s < 2; s++) begin
        set_meas(s ? 16'h0000 : 16'hFFFF);
        count_high(30, k);
        check("one-shot", k[15:0], (m == s) ? 16'h0005 : 16'h0000);
      end
    end
    $display("test one-shot done");
  endtask : t_shot

  task automatic t_sec();
    dev_cfg_t c;
    c = dflt();
    c.sec = c.prim;
    c.sec_en = 1'b1;
    c.sec_is_input = 1'b0;
    c.bool_mode = BOOL_AND;
    set_lvl(1'b0);
    load(c);
    set_meas(16'hFFFF);
    cyc(8);
    check("sec drives", sec_oe_n, 1'b0);
    check("sec level", sec_o, 1'b1);
    check("no combine", prim_result_o, 1'b1);
    load(dflt());
    cyc(4);
    check("sec off", sec_oe_n, 1'b1);
    $display("test secondary done");
  endtask : t_sec

  task automatic t_bool();
    dev_cfg_t c;
    int k;
    c = dflt();
    c.sec_en = 1'b1;
    c.bool_mode = BOOL_AND;
    load(c);
    cyc(LAT + 10);
    check("and off", prim_result_o, 1'b0);
    check("sec input", sec_input_o, 1'b0);
    set_lvl(1'b1);
    cyc(LAT - 4);
    check("and latency", prim_result_o, 1'b0);
    wait_res(1'b1, 20);
    check("sec input", sec_input_o, 1'b1);
    set_lvl(1'b0);
    repeat (5) @(posedge clk_sys_i);
    set_lvl(1'b1);
    count_high(LAT + 15, k);
    check("and glitch", k[15:0], LAT + 15);
    set_meas(16'h0000);
    wait_res(1'b0, LAT + 10);
    c.bool_mode = BOOL_OR;
    load(c);
    cyc(LAT - 4);
    check("or latency", prim_result_o, 1'b0);
    wait_res(1'b1, 20);
    set_lvl(1'b0);
    wait_res(1'b0, LAT + 10);
    set_meas(16'hFFFF);
    wait_res(1'b1, LAT + 10);
    $display("test boolean done");
  endtask : t_bool

  task automatic t_wake();
    int i;
    load(dflt());
    @(posedge clk_sys_i);
    wake_go <= 1'b1;
    @(posedge clk_sys_i);
    wake_go <= 1'b0;
    for (i = 0; i < 15 && io_link_mode_o !== 1'b1; i++) cyc(1);
    check("wake", io_link_mode_o, 1'b1);
    if (io_link_mode_o !== 1'b1) end_of_test();
    @(posedge clk_sys_i);
    link_tx_en_i <= 1'b1;
    link_txd_i <= 1'b1;
    cyc(8);
    check("link drive", prim_o, 1'b1);
    check("link oe_n", prim_oe_n, 1'b0);
    check("link rx", link_rxd_o, 1'b1);
    @(posedge clk_sys_i);
    link_tx_en_i <= 1'b0;
    cyc(8);
    check("link release", prim_oe_n, 1'b1);
    check("link rx low", link_rxd_o, 1'b0);
    @(posedge clk_sys_i);
    link_fallback_i <= 1'b1;
    @(posedge clk_sys_i);
    link_fallback_i <= 1'b0;
    cyc(4);
    check("fallback", io_link_mode_o, 1'b0);
    check("fallback oe_n", prim_oe_n, 1'b0);
    $display("test wake done");
  endtask : t_wake

  // Reset in mid-run must drop the line back to standard I/O
  task automatic t_rst_mid();
    @(posedge clk_sys_i);
    wake_go <= 1'b1;
    @(posedge clk_sys_i);
    wake_go <= 1'b0;
    cyc(12);
    check("rewake", io_link_mode_o, 1'b1);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    cyc(3);
    check("reset oe_n", prim_oe_n, 1'b0);
    check("reset link", io_link_mode_o, 1'b0);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cyc(2);
    check("after reset link", io_link_mode_o, 1'b0);
    set_meas(16'hFFFF);
    cyc(5);
    check("after reset single", prim_result_o, 1'b1);
    $display("test mid-run reset done");
  endtask : t_rst_mid

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cyc(2);
    t_reset();
    t_tables();
    t_delay();
    t_shot();
    t_sec();
    t_bool();
    t_wake();
    t_rst_mid();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
